// >>> design/fpc_pll_ctrl.v
`timescale 1ns/1ps
`include "fpc_defs.vh"
// Operation
// RULE1: Bypass bit 29 routes the reference around the secondary PLL.
// RULE2: Bit 28 picks core PLL output, else crystal, as reference.
// RULE3: Enable bit 27 runs the PLL; resets cleared.
// RULE4: Three-bit output divider held in bits 25:23, values 0 to 7.
// RULE5: Feedback multiplier F held in bits 20:8, range 1 to 0x1FFF.
// RULE6: Reference divider R in bits 5:0; reference divided by R+1.
// RULE7: Fraction register bit 31 enables fractional mode; resets to zero.
// RULE8: Effective multiplier is F plus (f+1)/(p+1); software keeps f below p.
// RULE9: Divider F first in each period, then F+1 for the rest.
// RULE10: Period counted in reference cycles divided by R+1.
// RULE11: Field f in bits 15:8 gives f+1 cycles using F+1.
// RULE12: Field p in bits 7:0 gives period of p+1 cycles.
// RULE13: Secondary PLL selectable as application divider source; core PLL otherwise.
// RULE14: Reserved bits read zero and writes to them do nothing.
module fpc_pll_ctrl #(
    parameter AW = 8,
    parameter FW = 13,
    parameter PW = 8
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [AW-1:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire xtal_ref_i,
    input wire core_pll_ref_i,
    output reg pll_ref_sel_core_o,
    output reg pll_ref_tick_o,
    output reg pll_enable_o,
    output reg pll_bypass_o,
    output reg [2:0] output_divider_setting_o,
    output reg [5:0] ref_div_o,
    output reg [FW:0] fb_div_o,
    output reg app_clk_from_aux_o
);
    reg [31:0] ctl_q;
    reg [31:0] frac_q;
    reg app_sel_q;
    reg xtal_s1_q;
    reg xtal_s2_q;
    reg xtal_s3_q;
    reg core_s1_q;
    reg core_s2_q;
    reg core_s3_q;
    reg [5:0] rdiv_cnt_q;
    reg tick_q;
    reg [31:0] rdata_d;
    wire aux_loop_bypass;
    wire aux_loop_ref_from_core;
    wire aux_loop_enable;
    wire fractional_mode_enable;
    wire [FW-1:0] f_int;
    wire [PW-1:0] fraction_high_count;
    wire [PW-1:0] frac_period;
    wire [5:0] r_div;
    wire ref_rise;
    wire [FW:0] seq_fb;
    wire [PW-1:0] seq_phase;

    assign aux_loop_bypass = ctl_q[`FPC_BIT_BYPASS];
    assign aux_loop_ref_from_core = ctl_q[`FPC_BIT_REFSEL];
    assign aux_loop_enable = ctl_q[`FPC_BIT_ENABLE];
    assign f_int = ctl_q[`FPC_F_HI:`FPC_F_LO];
    assign r_div = ctl_q[`FPC_R_HI:`FPC_R_LO];
    assign fractional_mode_enable = frac_q[`FPC_BIT_FRAC_EN];
    assign fraction_high_count = frac_q[`FPC_FH_HI:`FPC_FH_LO];
    assign frac_period = frac_q[`FPC_P_HI:`FPC_P_LO];

    // Register writes; masks keep reserved bits at zero
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctl_q <= `FPC_CTL_RESET; // RULE3
            frac_q <= `FPC_FRAC_RESET; // RULE7
            app_sel_q <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `FPC_ADDR_CTL) begin
                ctl_q <= reg_wdata_i & `FPC_CTL_MASK; // RULE14
            end
            if (reg_addr_i == `FPC_ADDR_FRAC) begin
                frac_q <= reg_wdata_i & `FPC_FRAC_MASK; // RULE14
            end
            if (reg_addr_i == `FPC_ADDR_CLKSEL) begin
                app_sel_q <= reg_wdata_i[`FPC_BIT_APP_SEL]; // RULE13
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr_i)
            `FPC_ADDR_CTL: rdata_d = ctl_q;
            `FPC_ADDR_FRAC: rdata_d = frac_q;
            `FPC_ADDR_CLKSEL: rdata_d = {app_sel_q, 31'h00000000};
            `FPC_ADDR_STATUS: begin
                rdata_d = {{(16-PW){1'b0}}, seq_phase, {(14-FW){1'b0}}, seq_fb, pll_ref_tick_o};
            end
            default: rdata_d = 32'h00000000;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

    // Reference pins come from other clocks: two flops before any logic
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
            core_s1_q <= 1'b0;
            core_s2_q <= 1'b0;
            core_s3_q <= 1'b0;
        end else begin
            xtal_s1_q <= xtal_ref_i;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
            core_s1_q <= core_pll_ref_i;
            core_s2_q <= core_s1_q;
            core_s3_q <= core_s2_q;
        end
    end

    // Reference edges are only seen if slower than half of core_clk_i
    assign ref_rise = aux_loop_ref_from_core ? (core_s2_q & ~core_s3_q)
                                             : (xtal_s2_q & ~xtal_s3_q); // RULE2

    // Divide the chosen reference by R+1 to form the comparator tick
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rdiv_cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (!aux_loop_enable) begin
                rdiv_cnt_q <= 6'h00;
            end else if (ref_rise) begin
                if (rdiv_cnt_q >= r_div) begin // RULE6
                    rdiv_cnt_q <= 6'h00;
                    tick_q <= 1'b1;
                end else begin
                    rdiv_cnt_q <= rdiv_cnt_q + 6'h01;
                end
            end
        end
    end

    fpc_frac_seq #(
        .FW(FW),
        .PW(PW)
    ) u_seq (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .active_i(aux_loop_enable & fractional_mode_enable), // RULE7
        .tick_i(tick_q), // RULE10
        .f_int_i(f_int),
        .frac_hi_i(fraction_high_count),
        .period_i(frac_period),
        .fb_div_o(seq_fb),
        .phase_o(seq_phase)
    );

    // Outputs registered toward the analog loop
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pll_ref_sel_core_o <= 1'b0;
            pll_ref_tick_o <= 1'b0;
            pll_enable_o <= 1'b0;
            pll_bypass_o <= 1'b0;
            output_divider_setting_o <= 3'h0;
            ref_div_o <= 6'h00;
            fb_div_o <= {(FW+1){1'b0}};
            app_clk_from_aux_o <= 1'b0;
        end else begin
            pll_ref_sel_core_o <= aux_loop_ref_from_core; // RULE2
            pll_ref_tick_o <= tick_q;
            pll_enable_o <= aux_loop_enable; // RULE3
            pll_bypass_o <= aux_loop_bypass; // RULE1
            output_divider_setting_o <= ctl_q[`FPC_OD_HI:`FPC_OD_LO]; // RULE4
            ref_div_o <= r_div; // RULE6
            fb_div_o <= seq_fb; // RULE5
            app_clk_from_aux_o <= app_sel_q; // RULE13
        end
    end
endmodule // fpc_pll_ctrl

// >>> design/fpc_defs.vh
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH
`define FPC_ADDR_CTL 8'h0f
`define FPC_ADDR_FRAC 8'h12
`define FPC_ADDR_CLKSEL 8'h0e
`define FPC_ADDR_STATUS 8'h13
`define FPC_BIT_BYPASS 29
`define FPC_BIT_REFSEL 28
`define FPC_BIT_ENABLE 27
`define FPC_OD_HI 25
`define FPC_OD_LO 23
`define FPC_F_HI 20
`define FPC_F_LO 8
`define FPC_R_HI 5
`define FPC_R_LO 0
`define FPC_BIT_FRAC_EN 31
`define FPC_FH_HI 15
`define FPC_FH_LO 8
`define FPC_P_HI 7
`define FPC_P_LO 0
`define FPC_BIT_APP_SEL 31
`define FPC_CTL_MASK 32'h3b9fff3f
`define FPC_FRAC_MASK 32'h8000ffff
`define FPC_CTL_RESET 32'h00000100
`define FPC_FRAC_RESET 32'h00000000
`endif

// >>> design/fpc_frac_seq.v
`timescale 1ns/1ps
// Alternates feedback divider between F and F+1 across a period of p+1 ticks
module fpc_frac_seq #(
    parameter FW = 13,
    parameter PW = 8
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire active_i,
    input wire tick_i,
    input wire [FW-1:0] f_int_i,
    input wire [PW-1:0] frac_hi_i,
    input wire [PW-1:0] period_i,
    output wire [FW:0] fb_div_o,
    output wire [PW-1:0] phase_o
);
    reg [PW-1:0] cnt_q;
    reg [PW-1:0] cnt_d;
    wire [PW:0] lo_len;
    wire use_hi;
    // F for the first p-f ticks, then F+1 for the last f+1 ticks
    assign lo_len = {1'b0, period_i} - {1'b0, frac_hi_i}; // RULE9
    assign use_hi = active_i && ({1'b0, cnt_q} >= lo_len); // RULE11
    assign fb_div_o = {1'b0, f_int_i} + {{FW{1'b0}}, use_hi}; // RULE8
    assign phase_o = cnt_q;
    always @* begin
        cnt_d = cnt_q;
        if (!active_i) begin
            cnt_d = {PW{1'b0}};
        end else if (tick_i) begin // RULE10
            if (cnt_q >= period_i) begin
                cnt_d = {PW{1'b0}}; // RULE12
            end else begin
                cnt_d = cnt_q + {{(PW-1){1'b0}}, 1'b1};
            end
        end
    end
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= {PW{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // fpc_frac_seq

// >>> testbench/fpc_pll_ctrl_props.sv
`timescale 1ns/1ps
module fpc_chk (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire pll_ref_sel_core_o,
    input wire pll_ref_tick_o,
    input wire pll_enable_o,
    input wire pll_bypass_o,
    input wire [2:0] output_divider_setting_o,
    input wire [5:0] ref_div_o,
    input wire app_clk_from_aux_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence ctl_wr;
        reg_wr_i && reg_addr_i == 8'h0f;
    endsequence
    sequence sel_wr;
        reg_wr_i && reg_addr_i == 8'h0e;
    endsequence
    a_bypass_follows: assert property (ctl_wr |-> ##2 pll_bypass_o == $past(reg_wdata_i[29], 2))
        else $error("bypass output wrong");
    a_refsel_follows: assert property (ctl_wr |-> ##2 pll_ref_sel_core_o == $past(reg_wdata_i[28], 2))
        else $error("reference select wrong");
    a_enable_follows: assert property (ctl_wr |-> ##2 pll_enable_o == $past(reg_wdata_i[27], 2))
        else $error("enable output wrong");
    a_outdiv_follows: assert property (ctl_wr |-> ##2 output_divider_setting_o == $past(reg_wdata_i[25:23], 2))
        else $error("output divider wrong");
    a_refdiv_follows: assert property (ctl_wr |-> ##2 ref_div_o == $past(reg_wdata_i[5:0], 2))
        else $error("reference divider wrong");
    a_app_sel: assert property (sel_wr |-> ##2 app_clk_from_aux_o == $past(reg_wdata_i[31], 2))
        else $error("application source wrong");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read cycle");
    a_tick_pulse: assert property (pll_ref_tick_o |=> !pll_ref_tick_o)
        else $error("tick longer than one cycle");
endmodule // fpc_chk

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`include "fpc_defs.vh"
module testbench;
    logic core_clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic xtal_ref_i = 0, core_pll_ref_i = 0, m_sel;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, m_ctl, m_frac, d;
    wire [31:0] reg_rdata_o;
    wire pll_ref_sel_core_o, pll_ref_tick_o, pll_enable_o, pll_bypass_o, app_clk_from_aux_o;
    wire [2:0] output_divider_setting_o;
    wire [5:0] ref_div_o;
    wire [13:0] fb_div_o;
    int n_errors = 0, num_checks = 0, cyc = 0, n1, n2, r, fv, p, f;
    fpc_pll_ctrl dut (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .xtal_ref_i, .core_pll_ref_i, .pll_ref_sel_core_o, .pll_ref_tick_o,
        .pll_enable_o, .pll_bypass_o, .output_divider_setting_o, .ref_div_o, .fb_div_o,
        .app_clk_from_aux_o);
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // Two unrelated reference rates so the source select shows in tick spacing
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        xtal_ref_i <= (cyc % 6) < 3;
        core_pll_ref_i <= (cyc % 8) < 4;
    end
    task step;
        @(posedge core_clk_i);
        #1;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        if (a == `FPC_ADDR_CTL) m_ctl = v & `FPC_CTL_MASK;
        if (a == `FPC_ADDR_FRAC) m_frac = v & `FPC_FRAC_MASK;
        if (a == `FPC_ADDR_CLKSEL) m_sel = v[31];
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        step;
        reg_wr_i <= 1'b0;
        step;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        step;
        reg_rd_i <= 1'b0;
        chk("read data", reg_rdata_o, exp);
        step;
    endtask
    task outs;
        chk("bypass", 32'(pll_bypass_o), 32'(m_ctl[29]));
        chk("ref select", 32'(pll_ref_sel_core_o), 32'(m_ctl[28]));
        chk("enable", 32'(pll_enable_o), 32'(m_ctl[27]));
        chk("out divider", 32'(output_divider_setting_o), 32'(m_ctl[25:23]));
        chk("ref divider", 32'(ref_div_o), 32'(m_ctl[5:0]));
        chk("feedback", 32'(fb_div_o), 32'(m_ctl[20:8]));
        chk("app source", 32'(app_clk_from_aux_o), 32'(m_sel));
        rd(`FPC_ADDR_CTL, m_ctl);
        rd(`FPC_ADDR_FRAC, m_frac);
        rd(`FPC_ADDR_CLKSEL, {m_sel, 31'h0});
    endtask
    task ft(input int rs);
        r = $urandom % 4;
        fv = 1 + $urandom % 100;
        p = 2 + $urandom % 6;
        f = $urandom % p;
        wr(`FPC_ADDR_CTL, 32'h08000000 | (rs << 28) | (fv << 8) | r);
        wr(`FPC_ADDR_FRAC, 32'h80000000 | (f << 8) | p);
        while (pll_ref_tick_o !== 1'b1) step;
        n1 = 0;
        step;
        while (pll_ref_tick_o !== 1'b1) begin
            n1++;
            step;
        end
        chk("tick spacing", n1 + 1, (r + 1) * (rs ? 8 : 6));
        // Start counting only at the beginning of a fresh high stretch
        while (fb_div_o !== fv) step;
        while (fb_div_o !== fv + 1) step;
        n1 = 0;
        n2 = 0;
        while (fb_div_o === fv + 1) begin
            n1 += (pll_ref_tick_o === 1'b1);
            step;
        end
        while (fb_div_o === fv) begin
            n2 += (pll_ref_tick_o === 1'b1);
            step;
        end
        chk("high ticks", n1, f + 1);
        chk("low ticks", n2, p - f);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk_i);
        n_errors++;
        wrap_up;
    end
    initial begin
        void'($urandom(74991));
        m_ctl = `FPC_CTL_RESET;
        m_frac = `FPC_FRAC_RESET;
        m_sel = 1'b0;
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        step;
        outs;
        rd(`FPC_ADDR_STATUS, 32'h00000002);
        $display("test reset done");
        repeat (6) begin
            d = $urandom;
            wr(`FPC_ADDR_CTL, d | 32'h100);
            wr(`FPC_ADDR_FRAC, d & 32'h7fffffff);
            wr(`FPC_ADDR_CLKSEL, $urandom);
            wr(8'h05, $urandom);
            outs;
            rd(8'h05, 32'h0);
        end
        $display("test registers done");
        // Fraction stays disabled above, so feedback equals F there
        ft(0);
        ft(1);
        $display("test fraction done");
        wrap_up;
    end
endmodule // testbench
bind fpc_pll_ctrl fpc_chk u_chk (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .pll_ref_sel_core_o, .pll_ref_tick_o, .pll_enable_o,
    .pll_bypass_o, .output_divider_setting_o, .ref_div_o, .app_clk_from_aux_o);
